/* File: tbd_pkg.sv */
// Constants, register map and field layout of the timer engine breakpoint debug block.
package tbd_pkg;

    // ------------------------------------------------------------------
    // Register indices, byte address is four times the index
    // ------------------------------------------------------------------
    localparam logic [7:0] TBD_IDX_ADDR1   = 8'h40;
    localparam logic [7:0] TBD_IDX_DATA1   = 8'h41;
    localparam logic [7:0] TBD_IDX_ADDR2   = 8'h42;
    localparam logic [7:0] TBD_IDX_DATA2   = 8'h43;
    localparam logic [7:0] TBD_IDX_TRACE   = 8'h44;
    localparam logic [7:0] TBD_IDX_EVCTL   = 8'h45;
    localparam logic [7:0] TBD_IDX_MPC     = 8'h46;
    localparam logic [7:0] TBD_IDX_FLAGS   = 8'h47;
    localparam logic [7:0] TBD_IDX_FORCED_MICROINSTRUCTION    = 8'h48;
    localparam logic [7:0] TBD_IDX_COMPCTL = 8'h49;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int TBD_MASK_LSB   = 18;
    localparam int TBD_CHANNEL_MATCH_VALUE_LSB   = 24;
    localparam int TBD_CHANNEL_MATCH_MASK_LSB  = 16;
    localparam int TBD_CRW_LSB    = 12;
    localparam int TBD_HSR_LSB    = 9;
    localparam int TBD_LINK_LSB   = 6;
    localparam int TBD_MRL_LSB    = 3;
    localparam int TBD_TDL_LSB    = 1;
    localparam int TBD_MPC_W      = 16;

    localparam logic [31:0] TBD_EVCTL_RESET = 32'h0000_0000;
    localparam logic [31:0] TBD_ZERO        = 32'h0000_0000;

    // Action field upper bits.
    localparam logic [1:0] TBD_ACT_BREAK = 2'h1;
    localparam logic [1:0] TBD_ACT_WATCH = 2'h3;

    // Comparator operand select in the compare control register.
    localparam logic [2:0] TBD_OP_DATA  = 3'h3;
    localparam logic [2:0] TBD_OP_IADDR = 3'h4;
    localparam logic [2:0] TBD_OP_DADDR = 3'h5;
    localparam logic [2:0] TBD_OP_BOTH  = 3'h7;

    // Data access sizes.
    localparam logic [1:0] TBD_SZ_8  = 2'h0;
    localparam logic [1:0] TBD_SZ_24 = 2'h2;
    localparam logic [1:0] TBD_SZ_32 = 2'h3;

    localparam int TBD_PULSE_CYCLES = 1;

endpackage

/* File: tbd_core.sv */
// Breakpoint, watchpoint, trace enable and halted-view debug logic with an APB slave.
//
// Decided for this implementation: the APB register port.
`timescale 1ns/10ps
`default_nettype none
module tbd_core
    import tbd_pkg::*;
#(
    parameter int CHANNELS = 32
) (
    input  wire logic        clock_i,
    input  wire logic        rst_b_i,
    input  wire logic        clk_en_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        halted_i,
    input  wire logic [4:0]  serviced_channel_i,
    input  wire logic        service_start_i,
    input  wire logic        host_request_i,
    input  wire logic        link_service_i,
    input  wire logic [1:0]  match_latch_i,
    input  wire logic [1:0]  transition_latch_i,
    input  wire logic [1:0]  internal_match_latch_i,
    input  wire logic [1:0]  internal_transition_latch_i,
    input  wire logic [31:0] serviced_channel_flags_i,
    input  wire logic [15:0] microprogram_counter_value_i,
    input  wire logic        channel_select_register_write_i,
    input  wire logic        ifetch_valid_i,
    input  wire logic [15:0] ifetch_addr_i,
    input  wire logic        mem_valid_i,
    input  wire logic        mem_write_i,
    input  wire logic [15:0] mem_addr_i,
    input  wire logic [1:0]  mem_size_i,
    input  wire logic [31:0] mem_wdata_i,
    input  wire logic        trace_mode_field_i,
    input  wire logic        watch_trace_i,
    output logic             halt_request_o,
    output logic             watch_hit_o,
    output logic             program_trace_o,
    output logic             forced_valid_o,
    output logic      [31:0] forced_instruction_word_o,
    output logic             event_output_n_o
);

    if (CHANNELS != 32) begin : g_bad_channels
        $error("tbd_core supports exactly 32 channels");
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [31:0] cmp_addr [2];
    logic [31:0] cmp_data [2];
    logic [2:0]  cmp_op   [2];
    logic [1:0]  cmp_en   [2];
    logic [1:0]  cmp_dir  [2];
    logic        cmp_evo  [2];
    logic [31:0] trace_en;
    logic [31:0] ev_ctl;

    logic        wr_acc;
    logic        rd_acc;
    logic [7:0]  idx;
    logic        mapped;

    assign idx      = paddr_i[9:2];
    assign wr_acc   = psel_i && penable_i && pwrite_i && clk_en_i;
    assign rd_acc   = psel_i && !pwrite_i;
    assign pready_o = 1'b1;
    assign mapped   = (paddr_i[11:10] == 2'h0) && (paddr_i[1:0] == 2'h0) &&
                      (idx >= TBD_IDX_ADDR1) && (idx <= TBD_IDX_COMPCTL);
    assign pslverr_o = psel_i && penable_i && !mapped;

    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            cmp_addr[0] <= TBD_ZERO;
            cmp_addr[1] <= TBD_ZERO;
            cmp_data[0] <= TBD_ZERO;
            cmp_data[1] <= TBD_ZERO;
            trace_en    <= TBD_ZERO;
            ev_ctl      <= TBD_EVCTL_RESET;
        end else if (wr_acc && mapped) begin
            unique case (idx)
                TBD_IDX_ADDR1: begin
                    cmp_addr[0] <= pwdata_i;
                end
                TBD_IDX_ADDR2: begin
                    cmp_addr[1] <= pwdata_i;
                end
                TBD_IDX_DATA1: begin
                    cmp_data[0] <= pwdata_i;
                end
                TBD_IDX_DATA2: begin
                    cmp_data[1] <= pwdata_i;
                end
                TBD_IDX_TRACE: begin
                    trace_en <= pwdata_i;
                end
                TBD_IDX_EVCTL: begin
                    ev_ctl <= pwdata_i;
                end
                default: begin
                end
            endcase
        end
    end

    // Compare control: per comparator an 8-bit lane holding op[2:0], dir[4:3], en[6:5], evo[7].
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            for (int k = 0; k < 2; k++) begin
                cmp_op[k]  <= 3'h0;
                cmp_dir[k] <= 2'h0;
                cmp_en[k]  <= 2'h0;
                cmp_evo[k] <= 1'b0;
            end
        end else if (wr_acc && mapped && idx == TBD_IDX_COMPCTL) begin
            for (int k = 0; k < 2; k++) begin
                cmp_op[k]  <= pwdata_i[8*k +: 3];
                cmp_dir[k] <= pwdata_i[8*k+3 +: 2];
                cmp_en[k]  <= pwdata_i[8*k+5 +: 2];
                cmp_evo[k] <= pwdata_i[8*k+7];
            end
        end
    end

    // ------------------------------------------------------------------
    // Forced microinstruction
    // ------------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            forced_valid_o            <= 1'b0;
            forced_instruction_word_o <= TBD_ZERO;
        end else if (clk_en_i) begin
            forced_valid_o <= 1'b0;
            if (wr_acc && mapped && idx == TBD_IDX_FORCED_MICROINSTRUCTION && halted_i) begin
                // The core drops any thread-end encoding it receives here.
                forced_valid_o            <= 1'b1;
                forced_instruction_word_o <= pwdata_i;
            end
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    logic [31:0] next_rdata;
    logic [31:0] flag_view;

    // Internal latch copies replace bits 7:4, which the channel logic leaves unused.
    assign flag_view = {serviced_channel_flags_i[31:24],
                        transition_latch_i[0], transition_latch_i[1],
                        match_latch_i[0], match_latch_i[1],
                        serviced_channel_flags_i[19:8],
                        internal_transition_latch_i[0], internal_transition_latch_i[1],
                        internal_match_latch_i[0], internal_match_latch_i[1],
                        serviced_channel_flags_i[3:0]};

    always_comb begin
        next_rdata = TBD_ZERO;
        unique case (idx)
            TBD_IDX_ADDR1:   next_rdata = cmp_addr[0];
            TBD_IDX_ADDR2:   next_rdata = cmp_addr[1];
            TBD_IDX_DATA1:   next_rdata = cmp_data[0];
            TBD_IDX_DATA2:   next_rdata = cmp_data[1];
            TBD_IDX_TRACE:   next_rdata = trace_en;
            TBD_IDX_EVCTL:   next_rdata = ev_ctl;
            TBD_IDX_MPC:     next_rdata = halted_i ? {16'h0000, microprogram_counter_value_i} : TBD_ZERO;
            TBD_IDX_FLAGS:   next_rdata = halted_i ? flag_view : TBD_ZERO;
            TBD_IDX_FORCED_MICROINSTRUCTION:    next_rdata = TBD_ZERO;
            TBD_IDX_COMPCTL: next_rdata = {16'h0000, cmp_evo[1], cmp_en[1], cmp_dir[1], cmp_op[1],
                                           cmp_evo[0], cmp_en[0], cmp_dir[0], cmp_op[0]};
            default:         next_rdata = TBD_ZERO;
        endcase
        if (!mapped) begin
            next_rdata = TBD_ZERO;
        end
    end

    // Read data is registered in the setup cycle, so the access phase always completes at once.
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            prdata_o <= TBD_ZERO;
        end else if (clk_en_i && rd_acc && !penable_i) begin
            prdata_o <= next_rdata;
        end
    end

    // ------------------------------------------------------------------
    // Address/data comparators
    // ------------------------------------------------------------------
    logic [1:0] cmp_break;
    logic [1:0] cmp_watch;

    for (genvar g = 0; g < 2; g++) begin : g_cmp
        logic [13:0] amask;
        logic        ia_hit;
        logic        da_hit;
        logic        d_hit;
        logic        dir_ok;
        logic        hit;
        logic [31:0] dmask;

        assign amask  = cmp_addr[g][31:TBD_MASK_LSB];
        // Word addresses: byte offset bits of the access are dropped.
        assign ia_hit = ifetch_valid_i &&
                        ((cmp_addr[g][15:2] & amask) == (ifetch_addr_i[15:2] & amask));
        assign da_hit = mem_valid_i &&
                        ((cmp_addr[g][13:2] & amask[11:0]) == (mem_addr_i[13:2] & amask[11:0]));
        always_comb begin
            dmask = 32'hFFFF_FFFF;
            unique case (mem_size_i)
                TBD_SZ_8:  dmask = 32'hFF00_0000;
                TBD_SZ_24: dmask = 32'h00FF_FFFF;
                TBD_SZ_32: dmask = 32'hFFFF_FFFF;
                default:   dmask = 32'hFFFF_FFFF;
            endcase
        end
        assign d_hit  = mem_valid_i && mem_write_i &&
                        ((cmp_data[g] & dmask) == (mem_wdata_i & dmask));
        assign dir_ok = (cmp_dir[g] == 2'h0) ? !mem_write_i :
                        (cmp_dir[g] == 2'h1) ? mem_write_i :
                        (cmp_dir[g] == 2'h2);
        always_comb begin
            hit = 1'b0;
            unique case (cmp_op[g])
                TBD_OP_DATA:  hit = d_hit;
                TBD_OP_IADDR: hit = ia_hit;
                TBD_OP_DADDR: hit = da_hit && dir_ok;
                TBD_OP_BOTH:  hit = d_hit && da_hit;
                default:      hit = 1'b0;
            endcase
        end
        assign cmp_break[g] = hit && (cmp_en[g] == TBD_ACT_BREAK);
        assign cmp_watch[g] = hit && (cmp_en[g] == TBD_ACT_WATCH);
    end

    // ------------------------------------------------------------------
    // Serviced channel events
    // ------------------------------------------------------------------
    logic       channel_select_register_hit;
    logic [4:0] ev_cause;
    logic [2:0] ev_act [5];
    logic [4:0] ev_brk;
    logic [4:0] ev_wat;
    logic [4:0] ev_out;

    assign channel_select_register_hit = ((ev_ctl[TBD_CHANNEL_MATCH_VALUE_LSB +: 5] & ev_ctl[TBD_CHANNEL_MATCH_MASK_LSB +: 5]) ==
                       (serviced_channel_i & ev_ctl[TBD_CHANNEL_MATCH_MASK_LSB +: 5]));
    assign ev_act[0] = ev_ctl[TBD_CRW_LSB +: 3];
    assign ev_act[1] = ev_ctl[TBD_HSR_LSB +: 3];
    assign ev_act[2] = ev_ctl[TBD_LINK_LSB +: 3];
    assign ev_act[3] = ev_ctl[TBD_MRL_LSB +: 3];
    // Transition field is two bits wide; its low bit serves as the routing bit.
    assign ev_act[4] = {ev_ctl[TBD_TDL_LSB +: 2], ev_ctl[TBD_TDL_LSB]};

    assign ev_cause[0] = channel_select_register_write_i;
    assign ev_cause[1] = service_start_i && host_request_i;
    assign ev_cause[2] = service_start_i && link_service_i;
    assign ev_cause[3] = service_start_i && |match_latch_i;
    assign ev_cause[4] = service_start_i && |transition_latch_i;

    for (genvar e = 0; e < 5; e++) begin : g_ev
        logic fire;
        assign fire      = channel_select_register_hit && ev_cause[e];
        // Reserved 10x decodes to neither action, as after reset.
        assign ev_brk[e] = fire && (ev_act[e][2:1] == TBD_ACT_BREAK);
        assign ev_wat[e] = fire && (ev_act[e][2:1] == TBD_ACT_WATCH);
        assign ev_out[e] = (ev_brk[e] || ev_wat[e]) && ev_act[e][0];
    end

    // Halt is combinational so the core stalls before the instruction or memory access.
    assign halt_request_o = |ev_brk || |cmp_break;
    assign watch_hit_o    = |ev_wat || |cmp_watch;

    // ------------------------------------------------------------------
    // Trace enable and event pin
    // ------------------------------------------------------------------
    assign program_trace_o = (trace_mode_field_i || watch_trace_i) &&
                             trace_en[serviced_channel_i];

    logic routed;
    assign routed = |ev_out || ((cmp_break[0] || cmp_watch[0]) && cmp_evo[0]) ||
                    ((cmp_break[1] || cmp_watch[1]) && cmp_evo[1]);

    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            event_output_n_o <= 1'b1;
        end else if (clk_en_i) begin
            event_output_n_o <= !routed;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    event_pin_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (clk_en_i && routed) |=> !event_output_n_o)
        else $error("Event pin did not pulse low.");

    forced_microinstruction_drop_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (clk_en_i && wr_acc && idx == TBD_IDX_FORCED_MICROINSTRUCTION && !halted_i) |=> !forced_valid_o)
        else $error("Forced instruction accepted while running.");

    forced_microinstruction_take_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (wr_acc && mapped && idx == TBD_IDX_FORCED_MICROINSTRUCTION && halted_i) |=>
        (forced_valid_o && forced_instruction_word_o == $past(pwdata_i)))
        else $error("Forced instruction not issued.");

    mpc_view_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (clk_en_i && rd_acc && !penable_i && idx == TBD_IDX_MPC && paddr_i[11:10] == 2'h0
         && paddr_i[1:0] == 2'h0) |=>
        (prdata_o == ($past(halted_i) ? {16'h0000, $past(microprogram_counter_value_i)} : 32'h0000_0000)))
        else $error("Counter view read wrong.");

    flags_read_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (clk_en_i && rd_acc && !penable_i && idx == TBD_IDX_FLAGS && !halted_i) |=> prdata_o == 32'h0000_0000)
        else $error("Flags visible while running.");

    forced_microinstruction_read_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (clk_en_i && rd_acc && !penable_i && idx == TBD_IDX_FORCED_MICROINSTRUCTION) |=> prdata_o == 32'h0000_0000)
        else $error("Forced instruction register read nonzero.");

    trace_gate_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (!trace_mode_field_i && !watch_trace_i) |-> !program_trace_o)
        else $error("Trace active without trace mode.");

    host_break_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (service_start_i && host_request_i && channel_select_register_hit && ev_ctl[TBD_HSR_LSB+1 +: 2] == 2'h1) |-> halt_request_o)
        else $error("Host request break missed.");

    reserved_act_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (ev_ctl[TBD_CRW_LSB+1 +: 2] == 2'h2 && channel_select_register_write_i) |-> !ev_brk[0] && !ev_wat[0])
        else $error("Reserved action acted.");

    link_break_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (service_start_i && link_service_i && channel_select_register_hit && ev_ctl[TBD_LINK_LSB+1 +: 2] == 2'h1) |-> halt_request_o)
        else $error("Link service break missed.");

    match_watch_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (service_start_i && |match_latch_i && channel_select_register_hit && ev_ctl[TBD_MRL_LSB+1 +: 2] == 2'h3) |-> watch_hit_o)
        else $error("Match latch watchpoint missed.");

    trans_break_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (service_start_i && |transition_latch_i && channel_select_register_hit && ev_ctl[TBD_TDL_LSB +: 2] == 2'h1) |-> halt_request_o)
        else $error("Transition latch break missed.");

    // A channel outside the masked match must never raise an event action.
    channel_select_register_miss_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        ((ev_ctl[TBD_CHANNEL_MATCH_VALUE_LSB +: 5] & ev_ctl[TBD_CHANNEL_MATCH_MASK_LSB +: 5]) !=
         (serviced_channel_i & ev_ctl[TBD_CHANNEL_MATCH_MASK_LSB +: 5])) |-> (!(|ev_brk) && !(|ev_wat)))
        else $error("Event fired on a channel mismatch.");

    trace_sel_a: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (trace_mode_field_i && !trace_en[serviced_channel_i]) |-> !program_trace_o)
        else $error("Trace on for a disabled channel.");

endmodule
`default_nettype wire

/* File: tbd_tool_model.sv */
// Debug tool model: an APB master that issues register transfers.
`timescale 1ns/10ps
`default_nettype none
module tbd_tool_model (
    input  wire logic        clock_i,
    output logic             psel_o,
    output logic             penable_o,
    output logic             pwrite_o,
    output logic      [11:0] paddr_o,
    output logic      [31:0] pwdata_o,
    input  wire logic [31:0] prdata_i,
    input  wire logic        pready_i,
    input  wire logic        pslverr_i
);
    initial begin
        {psel_o, penable_o, pwrite_o} = 3'h0;
        paddr_o  = 12'h000;
        pwdata_o = 32'h0000_0000;
    end

    // Released address and data are inverted so a stale value never passes for a live one.
    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                        output logic [31:0] rdata, output logic err);
        @(posedge clock_i);
        psel_o    <= 1'b1;
        penable_o <= 1'b0;
        pwrite_o  <= wr;
        paddr_o   <= {2'b00, idx, 2'b00};
        pwdata_o  <= wd;
        @(posedge clock_i);
        penable_o <= 1'b1;
        do begin
            @(posedge clock_i);
        end while (pready_i !== 1'b1);
        rdata     = prdata_i;
        err       = pslverr_i;
        psel_o    <= 1'b0;
        penable_o <= 1'b0;
        paddr_o   <= ~paddr_o;
        pwdata_o  <= ~pwdata_o;
    endtask
endmodule
`default_nettype wire

/* File: tbd_tb.sv */
// Self-checking bench for the timer engine breakpoint debug block.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin err_total++; \
    $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module tb
    import tbd_pkg::*;
;
    logic        clock_i, rst_b_i, clk_en_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, halted_i;
    logic        service_start_i, host_request_i, link_service_i, channel_select_register_write_i, ifetch_valid_i, mem_valid_i;
    logic        mem_write_i, trace_mode_field_i, watch_trace_i, halt_request_o, watch_hit_o, program_trace_o;
    logic        forced_valid_o, event_output_n_o, perr, hit;
    logic [1:0]  match_latch_i, transition_latch_i, internal_match_latch_i, internal_transition_latch_i;
    logic [1:0]  mem_size_i, act;
    logic [2:0]  cd;
    logic [4:0]  serviced_channel_i, ch;
    logic [5:0]  c;
    logic [11:0] paddr_i;
    logic [15:0] microprogram_counter_value_i, ifetch_addr_i, mem_addr_i;
    logic [31:0] pwdata_i, prdata_o, serviced_channel_flags_i, mem_wdata_i, forced_instruction_word_o;
    logic [31:0] seed, q, d, ev, f;
    logic [1:0]  szc[3] = '{TBD_SZ_8, TBD_SZ_24, TBD_SZ_32};
    logic [31:0] flips[3] = '{32'h0000_0000, 32'h8000_0000, 32'h0000_0001};
    int          lsb[5] = '{TBD_CRW_LSB, TBD_HSR_LSB, TBD_LINK_LSB, TBD_MRL_LSB, TBD_TDL_LSB};
    int          err_total = 0;
    int          compares = 0;

    tbd_core tbd_core_forced_microinstruction (
        .clock_i, .rst_b_i, .clk_en_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
        .pready_o, .pslverr_o, .halted_i, .serviced_channel_i, .service_start_i, .host_request_i,
        .link_service_i, .match_latch_i, .transition_latch_i, .internal_match_latch_i,
        .internal_transition_latch_i, .serviced_channel_flags_i, .microprogram_counter_value_i,
        .channel_select_register_write_i, .ifetch_valid_i, .ifetch_addr_i, .mem_valid_i, .mem_write_i, .mem_addr_i,
        .mem_size_i, .mem_wdata_i, .trace_mode_field_i, .watch_trace_i, .halt_request_o, .watch_hit_o,
        .program_trace_o, .forced_valid_o, .forced_instruction_word_o, .event_output_n_o
    );
    tbd_tool_model tbd_tool_model_forced_microinstruction (
        .clock_i, .psel_o(psel_i), .penable_o(penable_i), .pwrite_o(pwrite_i), .paddr_o(paddr_i),
        .pwdata_o(pwdata_i), .prdata_i(prdata_o), .pready_i(pready_o), .pslverr_i(pslverr_o)
    );

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic rd(input logic [7:0] idx, input logic [31:0] ex, input string nm);
        tbd_tool_model_forced_microinstruction.xfer(1'b0, idx, TBD_ZERO, q, perr);
        `CHK(nm, ex, q)
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] v);
        tbd_tool_model_forced_microinstruction.xfer(1'b1, idx, v, q, perr);
    endtask

    // The halt request is combinational, so it is judged in the cycle of its cause.
    task automatic expect_hit(input logic b, input logic w, input logic e);
        @(negedge clock_i);
        `CHK("halt request", b, halt_request_o)
        `CHK("watch hit", w, watch_hit_o)
        @(posedge clock_i);
        {channel_select_register_write_i, service_start_i, mem_valid_i, ifetch_valid_i} <= 4'h0;
        mem_wdata_i <= ~mem_wdata_i;
        @(negedge clock_i);
        `CHK("event output", ~e, event_output_n_o)
    endtask

    function automatic logic [31:0] flags_exp();
        logic [31:0] r;
        r = serviced_channel_flags_i;
        r[23:20] = {transition_latch_i[0], transition_latch_i[1], match_latch_i[0], match_latch_i[1]};
        r[7:4] = {internal_transition_latch_i[0], internal_transition_latch_i[1],
                  internal_match_latch_i[0], internal_match_latch_i[1]};
        return r;
    endfunction

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end

    initial begin
        #200000;
        err_total++;
        summarize();
    end

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    initial begin
        seed = 32'h58d6_cde8;
        {rst_b_i, halted_i, service_start_i, host_request_i, link_service_i, channel_select_register_write_i} = 6'h00;
        {ifetch_valid_i, mem_valid_i, mem_write_i, trace_mode_field_i, watch_trace_i} = 5'h00;
        clk_en_i = 1'b1;
        {match_latch_i, transition_latch_i, internal_match_latch_i, internal_transition_latch_i} = 8'h00;
        {mem_size_i, serviced_channel_i, ifetch_addr_i, mem_addr_i} = 39'h00_0000_0000;
        {serviced_channel_flags_i, mem_wdata_i, microprogram_counter_value_i} = 80'h0;
        repeat (3) @(posedge clock_i);
        rst_b_i <= 1'b1;
        rd(TBD_IDX_EVCTL, TBD_EVCTL_RESET, "event control reset");
        d = $random(seed);
        microprogram_counter_value_i <= d[31:16];
        {match_latch_i, transition_latch_i, internal_match_latch_i, internal_transition_latch_i} <= d[7:0];
        serviced_channel_flags_i <= $random(seed);
        for (int h = 0; h < 2; h++) begin
            halted_i <= h[0];
            wr(TBD_IDX_FORCED_MICROINSTRUCTION, d);
            @(negedge clock_i);
            `CHK("forced valid", h[0], forced_valid_o)
            if (h == 1) `CHK("forced word", d, forced_instruction_word_o)
            rd(TBD_IDX_FORCED_MICROINSTRUCTION, TBD_ZERO, "forced read");
            rd(TBD_IDX_MPC, (h == 1) ? {16'h0000, d[31:16]} : TBD_ZERO, "counter view");
            rd(TBD_IDX_FLAGS, (h == 1) ? flags_exp() : TBD_ZERO, "flags view");
        end
        halted_i <= 1'b0;
        for (int k = 0; k < 5; k++) begin
            for (int j = 0; j < 8; j++) begin
                d = $random(seed);
                if (d[11]) d[4:0] = d[28:24];
                cd = j[2:0];
                ch = d[4:0];
                c = d[10:5];
                act = (k == 4) ? cd[1:0] : cd[2:1];
                f = (k == 4) ? {30'h0000_0000, cd[1:0]} : {29'h0000_0000, cd};
                ev = {3'b000, d[28:24], 3'b000, d[20:16], 16'h0000} | (f << lsb[k]);
                hit = ((d[28:24] & d[20:16]) == (ch & d[20:16])) && act[0] && ((k == 0) ||
                      (k == 1 && c[0]) || (k == 2 && c[1]) || (k == 3 && |c[3:2]) || (k == 4 && |c[5:4]));
                wr(TBD_IDX_EVCTL, ev);
                @(posedge clock_i);
                channel_select_register_write_i <= (k == 0);
                service_start_i <= (k != 0);
                serviced_channel_i <= ch;
                {link_service_i, host_request_i} <= c[1:0];
                match_latch_i <= c[3:2];
                transition_latch_i <= c[5:4];
                expect_hit(hit & ~act[1], hit & act[1], hit & cd[0]);
            end
        end
        wr(TBD_IDX_EVCTL, TBD_ZERO);
        wr(TBD_IDX_COMPCTL, 32'h0000_00B5);
        for (int i = 0; i < 8; i++) begin
            d = $random(seed);
            wr(TBD_IDX_ADDR1, {14'h3FFF, 2'b00, d[15:2], 2'b00});
            @(posedge clock_i);
            mem_valid_i <= 1'b1;
            mem_write_i <= d[24];
            mem_addr_i <= {d[17:16], d[13:2] ^ (i[0] ? 12'h000 : 12'h001 << i), d[19:18]};
            expect_hit(i[0], 1'b0, i[0]);
        end
        wr(TBD_IDX_COMPCTL, 32'h0000_002B);
        d = $random(seed);
        wr(TBD_IDX_DATA1, d);
        for (int i = 0; i < 9; i++) begin
            @(posedge clock_i);
            {mem_valid_i, mem_write_i, ifetch_valid_i} <= 3'h7;
            mem_size_i <= szc[i / 3];
            mem_wdata_i <= d ^ flips[i % 3];
            ifetch_addr_i <= mem_addr_i;
            expect_hit((i % 3 == 0) || i == 2 || i == 4, 1'b0, 1'b0);
        end
        for (int i = 0; i < 4; i++) begin
            d = $random(seed);
            wr(TBD_IDX_ADDR1 + i[7:0], d);
            rd(TBD_IDX_ADDR1 + i[7:0], d, "compare register");
        end
        ev = $random(seed);
        wr(TBD_IDX_TRACE, ev);
        rd(TBD_IDX_TRACE, ev, "trace enables");
        clk_en_i <= 1'b0;
        wr(TBD_IDX_TRACE, ~ev);
        clk_en_i <= 1'b1;
        rd(TBD_IDX_TRACE, ev, "frozen write");
        for (int i = 0; i < 16; i++) begin
            d = $random(seed);
            @(posedge clock_i);
            serviced_channel_i <= d[4:0];
            {watch_trace_i, trace_mode_field_i} <= d[6:5];
            @(negedge clock_i);
            `CHK("program trace", ev[d[4:0]] & (d[5] | d[6]), program_trace_o)
        end
        rd(8'h50, TBD_ZERO, "unmapped read");
        `CHK("unmapped error", 1'b1, perr)
        summarize();
    end
endmodule
`undef CHK
`default_nettype wire
